// file: pkg/fdhc_pkg.sv
// constants shared by both ends of the flash disk host control registers
// assumes one sys_clk domain, byte addresses inside an 8 KiB window
//
// Contract
// - two fixed read-only 16-bit identification words
// - scratch byte stored, read back, resets zero
// - claim byte readable, writable, resets zero
// - host polls claim until it reads zero
// - host writes unique id, reads back, retries
// - owner writes zero to release claim
// - low swap bit set swaps data bytes
// - high swap bit mirrors low swap bit
// - byte-order resets zero; 8-bit hosts skip it
// - host follows control write with complement confirm
// - nothing between control write and its confirm
// - mode field: 00 reset, 01 normal, 10 power-down
// - unlock bit needed for mode change, reads zero
// - boot-detect flag set on boot reset, W1C
// - hard-reset flag set on pin/voltage, W1C, resets one
// - confirm write-only; control bits 7-5 read zero
// - all reads return zero in reset mode
package fdhc_pkg;

  localparam int AW = 13;
  localparam int DW = 16;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] A_SIG_LO   = 13'h1000;
  localparam logic [AW-1:0] A_SCRATCH  = 13'h1004;
  localparam logic [AW-1:0] A_CLAIM    = 13'h1006;
  localparam logic [AW-1:0] A_BYTE_ORD = 13'h1008;
  localparam logic [AW-1:0] A_MODE_CTL = 13'h100C;
  localparam logic [AW-1:0] A_CONFIRM  = 13'h1072;
  localparam logic [AW-1:0] A_SIG_HI   = 13'h1074;
  localparam logic [AW-1:0] A_DATA     = 13'h0800;
  // boot block: sections 0 and 3
  localparam logic [AW-1:0] A_SEC1     = 13'h0800;
  localparam logic [AW-1:0] A_SEC3     = 13'h1800;

  // signature values are arbitrary
  localparam logic [DW-1:0] SIG_LO_VAL = 16'hA5C3;
  localparam logic [DW-1:0] SIG_HI_VAL = 16'h5A3C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int B_SWAP_LO = 0;
  localparam int B_SWAP_HI = 8;
  localparam int B_UNLOCK  = 2;
  localparam int B_BOOT    = 3;
  localparam int B_HARD    = 4;

  localparam logic [1:0] MODE_RESET  = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h1;
  localparam logic [1:0] MODE_DPD    = 2'h2;
  localparam logic [1:0] MODE_BAD    = 2'h3;

  // ----------------------------------------------------------------
  // host controller own register map and commands
  // ----------------------------------------------------------------
  localparam logic [2:0] HR_ADDR = 3'h0;
  localparam logic [2:0] HR_DATA = 3'h1;
  localparam logic [2:0] HR_CMD  = 3'h2;
  localparam logic [2:0] HR_STAT = 3'h3;
  localparam logic [2:0] HR_ID   = 3'h4;

  localparam logic [2:0] OP_READ    = 3'h1;
  localparam logic [2:0] OP_WRITE   = 3'h2;
  localparam logic [2:0] OP_MODE    = 3'h3;
  localparam logic [2:0] OP_CLAIM   = 3'h4;
  localparam logic [2:0] OP_RELEASE = 3'h5;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [DW-1:0] WORD_ZERO = 16'h0000;

endpackage

// file: pkg/fdhc_link_if.sv
// memory-mapped host bus between host cpu end and device register end
// assumes both ends on sys_clk; read data stands the cycle after re
`timescale 1ns/1ns
interface fdhc_link_if;
  import fdhc_pkg::*;

  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic          we;
  logic          re;
  logic [DW-1:0] rdata;

  modport dev
  (
    input  addr,
    input  wdata,
    input  we,
    input  re,
    output rdata
  );

  modport host
  (
    output addr,
    output wdata,
    output we,
    output re,
    input  rdata
  );

endinterface

// file: rtl/fdhc_device.sv
// device end: identification, scratch, claim, byte order, mode control
// assumes a host on fdhc_link_if.dev; reset_input_n and volt_detect pass two-flop synchronisers, boot_detect does not
`timescale 1ns/1ns
module fdhc_device
  import fdhc_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // host link
  fdhc_link_if.dev               link,
  // reset sources
  input  wire logic              reset_input_n,
  input  wire logic              volt_detect,
  input  wire logic              boot_detect,
  // flash data path
  input  wire logic [fdhc_pkg::DW-1:0] flash_rdata,
  output logic      [fdhc_pkg::DW-1:0] flash_wdata,
  output logic                   flash_wr,
  // operating state
  output logic      [1:0]        op_mode,
  output logic                   byte_swap_en
);
  import fdhc_pkg::*;

  typedef struct packed {
    logic [DW-1:0] rdata;
    logic [7:0]    scratch;
    logic [7:0]    claim;
    logic          low_byte_swap_en;
    logic          high_byte_swap_en;
    logic          swap;
    logic [1:0]    mode;
    logic          boot_detect_flag;
    logic          hard_reset_flag;
    logic          pend_vld;
    logic [7:0]    pend;
    logic [1:0]    pin_sync;
    logic [1:0]    volt_sync;
    logic [DW-1:0] fwdata;
    logic          fwr;
  } fdhc_dev_st_t;

  fdhc_dev_st_t st;
  fdhc_dev_st_t next_st;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic          boot_blk;
    logic          hard_evt;
    logic          commit;
    logic [DW-1:0] swapped_rd;
    logic [DW-1:0] swapped_wr;
    logic [DW-1:0] rd;
    boot_blk   = (link.addr < A_SEC1) || (link.addr >= A_SEC3);
    hard_evt   = 1'b0;
    commit     = 1'b0;
    swapped_rd = flash_rdata;
    swapped_wr = link.wdata;
    rd         = WORD_ZERO;
    next_st    = st;
    next_st.fwr = 1'b0;

    // only the second flop of each synchroniser is read
    next_st.pin_sync  = {st.pin_sync[0], reset_input_n};
    next_st.volt_sync = {st.volt_sync[0], volt_detect};
    hard_evt = !st.pin_sync[1] || st.volt_sync[1];

    if (st.swap)
    begin
      swapped_rd = {flash_rdata[7:0], flash_rdata[15:8]};
      swapped_wr = {link.wdata[7:0], link.wdata[15:8]};
    end

    // ----------------------------------------------------------------
    // reads, answered one cycle later
    // ----------------------------------------------------------------
    if (link.re && (st.mode != MODE_RESET))
    begin
      unique case (link.addr)
        A_SIG_LO:   rd = SIG_LO_VAL;
        A_SIG_HI:   rd = SIG_HI_VAL;
        A_SCRATCH:  rd = {8'h00, st.scratch};
        A_CLAIM:    rd = {8'h00, st.claim};
        A_BYTE_ORD: rd = {7'h00, st.high_byte_swap_en, 7'h00, st.low_byte_swap_en};
        // unlock bit and bits 7-5 read zero
        A_MODE_CTL: rd = {11'h000, st.hard_reset_flag, st.boot_detect_flag, 1'b0, st.mode};
        A_DATA:     rd = swapped_rd;
        // confirm register is write-only
        default:    rd = WORD_ZERO;
      endcase
    end
    next_st.rdata = rd;

    // ----------------------------------------------------------------
    // plain register writes
    // ----------------------------------------------------------------
    if (link.we)
    begin
      unique case (link.addr)
        A_SCRATCH:  next_st.scratch = link.wdata[7:0];
        A_CLAIM:    next_st.claim = link.wdata[7:0];
        A_BYTE_ORD:
        begin
          next_st.low_byte_swap_en  = link.wdata[B_SWAP_LO];
          next_st.high_byte_swap_en = link.wdata[B_SWAP_HI];
        end
        A_DATA:
        begin
          next_st.fwdata = swapped_wr;
          next_st.fwr    = 1'b1;
        end
        default:    next_st.fwr = 1'b0;
      endcase
    end

    // ----------------------------------------------------------------
    // control write and confirmation pairing
    // ----------------------------------------------------------------
    // a boot block read may sit between the pair; any other access kills it
    if (st.pend_vld && (link.we || (link.re && !boot_blk)))
    begin
      next_st.pend_vld = 1'b0;
      commit = link.we && (link.addr == A_CONFIRM) && (link.wdata[7:0] == ~st.pend);
    end
    if (link.we && (link.addr == A_MODE_CTL))
    begin
      next_st.pend     = link.wdata[7:0];
      next_st.pend_vld = 1'b1;
    end
    if (commit)
    begin
      // mode moves only with unlock; the unused code is refused
      if (st.pend[B_UNLOCK] && (st.pend[1:0] != MODE_BAD))
        next_st.mode = st.pend[1:0];
      if (st.pend[B_BOOT])
        next_st.boot_detect_flag = 1'b0;
      if (st.pend[B_HARD])
        next_st.hard_reset_flag = 1'b0;
    end

    // ----------------------------------------------------------------
    // reset mode entry; a set beats a same-cycle clear
    // ----------------------------------------------------------------
    if (boot_detect || hard_evt)
    begin
      next_st.mode              = MODE_RESET;
      next_st.pend_vld          = 1'b0;
      next_st.scratch           = BYTE_ZERO;
      next_st.claim             = BYTE_ZERO;
      next_st.low_byte_swap_en  = 1'b0;
      next_st.high_byte_swap_en = 1'b0;
    end
    if (boot_detect)
      next_st.boot_detect_flag = 1'b1;
    if (hard_evt)
      next_st.hard_reset_flag = 1'b1;

    // either mirrored bit enables, so host endianness does not matter
    next_st.swap = next_st.low_byte_swap_en || next_st.high_byte_swap_en;

    if (!rstn)
    begin
      next_st                 = '0;
      next_st.mode            = MODE_RESET;
      next_st.hard_reset_flag = 1'b1;
      next_st.pin_sync        = 2'h3;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    st <= next_st;
  end

  assign link.rdata   = st.rdata;
  assign flash_wdata  = st.fwdata;
  assign flash_wr     = st.fwr;
  assign op_mode      = st.mode;
  assign byte_swap_en = st.swap;

endmodule

// file: rtl/fdhc_host.sv
// host end: sequences single accesses, mode changes and bus claims
// assumes fdhc_link_if.host toward the device, software on a plain port
`timescale 1ns/1ns
module fdhc_host
  import fdhc_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // software port
  input  wire logic [2:0]        sw_addr,
  input  wire logic [fdhc_pkg::DW-1:0] sw_wdata,
  input  wire logic              sw_we,
  input  wire logic              sw_re,
  output logic      [fdhc_pkg::DW-1:0] sw_rdata,
  // device link
  fdhc_link_if.host              link
);
  import fdhc_pkg::*;

  typedef enum logic [8:0] {
    H_IDLE = 9'h001,
    H_RD1  = 9'h002,
    H_RD2  = 9'h004,
    H_CONF = 9'h008,
    H_P1   = 9'h010,
    H_P2   = 9'h020,
    H_K0   = 9'h040,
    H_K1   = 9'h080,
    H_K2   = 9'h100
  } fdhc_hst_t;

  typedef struct packed {
    fdhc_hst_t     state;
    logic [AW-1:0] tgt;
    logic [DW-1:0] data;
    logic [7:0]    cpu_id;
    logic          granted;
    logic [DW-1:0] sw_rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          we;
    logic          re;
  } fdhc_host_st_t;

  fdhc_host_st_t st;
  fdhc_host_st_t next_st;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st       = st;
    next_st.we    = 1'b0;
    next_st.re    = 1'b0;
    next_st.sw_rd = WORD_ZERO;

    if (sw_re)
    begin
      unique case (sw_addr)
        HR_ADDR: next_st.sw_rd = {3'h0, st.tgt};
        HR_DATA: next_st.sw_rd = st.data;
        HR_STAT: next_st.sw_rd = {14'h0000, st.granted, st.state != H_IDLE};
        HR_ID:   next_st.sw_rd = {8'h00, st.cpu_id};
        default: next_st.sw_rd = WORD_ZERO;
      endcase
    end
    if (sw_we && (sw_addr == HR_ADDR))
      next_st.tgt = sw_wdata[AW-1:0];
    if (sw_we && (sw_addr == HR_DATA))
      next_st.data = sw_wdata;
    if (sw_we && (sw_addr == HR_ID))
      next_st.cpu_id = sw_wdata[7:0];

    unique case (st.state)
      H_IDLE:
      begin
        // commands arriving while busy are dropped
        if (sw_we && (sw_addr == HR_CMD))
        begin
          unique case (sw_wdata[2:0])
            OP_READ:
            begin
              next_st.addr  = st.tgt;
              next_st.re    = 1'b1;
              next_st.state = H_RD1;
            end
            OP_WRITE:
            begin
              next_st.addr  = st.tgt;
              next_st.wdata = st.data;
              next_st.we    = 1'b1;
            end
            OP_MODE:
            begin
              next_st.addr  = A_MODE_CTL;
              next_st.wdata = {8'h00, st.data[7:0]};
              next_st.we    = 1'b1;
              next_st.state = H_CONF;
            end
            OP_CLAIM:
            begin
              next_st.addr  = A_CLAIM;
              next_st.re    = 1'b1;
              next_st.state = H_P1;
            end
            OP_RELEASE:
            begin
              next_st.addr    = A_CLAIM;
              next_st.wdata   = WORD_ZERO;
              next_st.we      = 1'b1;
              next_st.granted = 1'b0;
            end
            default: next_st.state = H_IDLE;
          endcase
        end
      end
      H_RD1:   next_st.state = H_RD2;
      H_RD2:
      begin
        next_st.data  = link.rdata;
        next_st.state = H_IDLE;
      end
      H_CONF:
      begin
        // confirm goes out on the very next cycle, nothing in between
        next_st.addr  = A_CONFIRM;
        next_st.wdata = {8'h00, ~st.data[7:0]};
        next_st.we    = 1'b1;
        next_st.state = H_IDLE;
      end
      H_P1:    next_st.state = H_P2;
      H_P2:
      begin
        if (link.rdata[7:0] != BYTE_ZERO)
        begin
          next_st.re    = 1'b1;
          next_st.state = H_P1;
        end
        else
        begin
          next_st.wdata = {8'h00, st.cpu_id};
          next_st.we    = 1'b1;
          next_st.state = H_K0;
        end
      end
      H_K0:
      begin
        next_st.re    = 1'b1;
        next_st.state = H_K1;
      end
      H_K1:    next_st.state = H_K2;
      H_K2:
      begin
        if (link.rdata[7:0] == st.cpu_id)
        begin
          next_st.granted = 1'b1;
          next_st.state   = H_IDLE;
        end
        else
        begin
          next_st.re    = 1'b1;
          next_st.state = H_P1;
        end
      end
    endcase

    if (!rstn)
    begin
      next_st       = '0;
      next_st.state = H_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    st <= next_st;
  end

  // byte order left at reset: this host works on the low byte
  assign sw_rdata    = st.sw_rd;
  assign link.addr   = st.addr;
  assign link.wdata  = st.wdata;
  assign link.we     = st.we;
  assign link.re     = st.re;

endmodule

// file: dv/fdhc_link_checker.sv
// link checker for the flash disk host control registers
// assumes one clock; tb instantiates it beside the link interface
`timescale 1ns/1ns
module fdhc_link_checker
  import fdhc_pkg::*;
(
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  // link
  input  wire logic [fdhc_pkg::AW-1:0] addr,
  input  wire logic [fdhc_pkg::DW-1:0] wdata,
  input  wire logic                   we,
  input  wire logic                   re,
  input  wire logic [fdhc_pkg::DW-1:0] rdata
);
  import fdhc_pkg::*;

  // ------------------------------
  // helpers
  // ------------------------------
  logic       claim_rd;
  logic       claim_free;
  logic       ctl_wr;
  logic [7:0] ctl_byte;

  // claim read answer lands one cycle after its strobe
  always_ff @(posedge sys_clk)
  begin
    claim_rd   <= rstn && re && addr == A_CLAIM;
    claim_free <= rstn && claim_rd && rdata[7:0] == 8'h00;
    ctl_wr     <= rstn && we && addr == A_MODE_CTL;
    ctl_byte   <= wdata[7:0];
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // ------------------------------
  // properties
  // ------------------------------
  property p_sig_lo;
    re && addr == A_SIG_LO |=> rdata == SIG_LO_VAL || rdata == WORD_ZERO;
  endproperty
  a_sig_lo: assert property (p_sig_lo) else $error("low signature wrong");

  property p_sig_hi;
    re && addr == A_SIG_HI |=> rdata == SIG_HI_VAL || rdata == WORD_ZERO;
  endproperty
  a_sig_hi: assert property (p_sig_hi) else $error("high signature wrong");

  property p_confirm_rd;
    re && addr == A_CONFIRM |=> rdata == WORD_ZERO;
  endproperty
  a_confirm_rd: assert property (p_confirm_rd) else $error("confirm readable");

  property p_unlock_rd;
    re && addr == A_MODE_CTL |=> !rdata[B_UNLOCK];
  endproperty
  a_unlock_rd: assert property (p_unlock_rd) else $error("unlock bit read as one");

  property p_ctl_upper;
    re && addr == A_MODE_CTL |=> rdata[15:5] == 11'h000;
  endproperty
  a_ctl_upper: assert property (p_ctl_upper) else $error("control upper bits set");

  property p_confirm_next;
    we && addr == A_MODE_CTL |=> we && addr == A_CONFIRM;
  endproperty
  a_confirm_next: assert property (p_confirm_next) else $error("confirm not next");

  property p_confirm_val;
    we && addr == A_CONFIRM |-> ctl_wr && wdata[7:0] == ~ctl_byte;
  endproperty
  a_confirm_val: assert property (p_confirm_val) else $error("confirm not complement");

  // only a free claim may be taken
  property p_claim_free;
    we && addr == A_CLAIM && wdata[7:0] != 8'h00 |-> claim_free;
  endproperty
  a_claim_free: assert property (p_claim_free) else $error("claim without free read");

  c_confirm: cover property (we && addr == A_CONFIRM);
  c_claim: cover property (we && addr == A_CLAIM && wdata[7:0] != 8'h00);
  c_sig: cover property (re && addr == A_SIG_HI);
endmodule

// file: dv/tb.sv
// testbench: host end drives device end over the link
// assumes software port of the host end as the link stimulus path; reset pins and flash_rdata driven directly
`timescale 1ns/1ns
module tb;
  import fdhc_pkg::*;
  logic          sys_clk;
  logic          rstn;
  logic [2:0]    sw_addr;
  logic [DW-1:0] sw_wdata;
  logic          sw_we;
  logic          sw_re;
  logic [DW-1:0] sw_rdata;
  logic          reset_input_n;
  logic          boot_detect;
  logic          volt_detect;
  logic [DW-1:0] flash_rdata;
  logic [DW-1:0] flash_wdata;
  logic          flash_wr;
  logic [DW-1:0] fw_last;
  logic [1:0]    op_mode;
  logic          byte_swap_en;
  logic [DW-1:0] last_rd;
  logic [DW-1:0] exp_q[$];
  bit            chk_q[$];
  logic          re_q;
  logic [7:0]    id;
  logic [7:0]    sv;
  logic [9:0]    mv [6] = '{10'h206, 10'h105, 10'h107, 10'h102, 10'h004, 10'h105};
  int            fails;
  int            checks_done;

  fdhc_link_if link ();
  fdhc_device fdhc_device_inst (.sys_clk(sys_clk), .rstn(rstn), .link(link),
    .reset_input_n(reset_input_n), .volt_detect(volt_detect), .boot_detect(boot_detect),
    .flash_rdata(flash_rdata), .flash_wdata(flash_wdata), .flash_wr(flash_wr), .op_mode(op_mode),
    .byte_swap_en(byte_swap_en));
  fdhc_host fdhc_host_inst (.sys_clk(sys_clk), .rstn(rstn), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata), .link(link));
  fdhc_link_checker fdhc_link_checker_inst (.sys_clk(sys_clk), .rstn(rstn),
    .addr(link.addr), .wdata(link.wdata), .we(link.we), .re(link.re), .rdata(link.rdata));

  // ------------------------------
  // tasks
  // ------------------------------
  task automatic check(input string name, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic sw_wr(input logic [2:0] a, input logic [DW-1:0] d);
    @(posedge sys_clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_we    <= 1'b1;
    @(posedge sys_clk);
    sw_we <= 1'b0;
  endtask

  task automatic sw_rd(input logic [2:0] a, input logic [DW-1:0] e, input bit c);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_re   <= 1'b1;
    exp_q.push_back(e);
    chk_q.push_back(c);
    @(posedge sys_clk);
    sw_re <= 1'b0;
    #1 last_rd = sw_rdata;
  endtask

  // poll busy; bounded so a stuck host counts a failure and the run goes on
  task automatic cmd(input logic [2:0] op);
    int n;
    sw_wr(HR_CMD, {13'h0000, op});
    n = 0;
    do
    begin
      sw_rd(HR_STAT, WORD_ZERO, 1'b0);
      n++;
    end
    while (last_rd[0] !== 1'b0 && n < 200);
    if (last_rd[0] !== 1'b0)
      fails++;
  endtask

  task automatic dev_rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
    sw_wr(HR_ADDR, {3'h0, a});
    cmd(OP_READ);
    sw_rd(HR_DATA, e, 1'b1);
  endtask

  task automatic dev_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    sw_wr(HR_ADDR, {3'h0, a});
    sw_wr(HR_DATA, d);
    cmd(OP_WRITE);
  endtask

  task automatic set_mode(input logic [7:0] d);
    sw_wr(HR_DATA, {8'h00, d});
    cmd(OP_MODE);
  endtask

  task automatic give_verdict();
    if (fails == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ------------------------------
  // monitor, clock, watchdog
  // ------------------------------
  always @(posedge sys_clk)
    re_q <= sw_re;

  // flash write pulse stands one cycle; keep the word it carried
  always @(posedge sys_clk)
    if (flash_wr === 1'b1)
      fw_last <= flash_wdata;

  always @(negedge sys_clk)
    if (re_q && exp_q.size() > 0)
    begin
      if (chk_q.pop_front())
        check("sw_rdata", sw_rdata, exp_q[0]);
      void'(exp_q.pop_front());
    end

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial
  begin
    #200000;
    fails++;
    give_verdict();
  end

  // ------------------------------
  // scenarios
  // ------------------------------
  initial
  begin
    rstn          = 1'b0;
    sw_addr       = 3'h0;
    sw_wdata      = WORD_ZERO;
    sw_we         = 1'b0;
    sw_re         = 1'b0;
    reset_input_n = 1'b1;
    boot_detect   = 1'b0;
    volt_detect   = 1'b0;
    fw_last       = WORD_ZERO;
    fails         = 0;
    checks_done   = 0;
    void'($urandom(4244));
    flash_rdata = 16'($urandom);
    id          = 8'($urandom) | 8'h01;
    sv          = 8'($urandom);
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    dev_rd(A_SIG_LO, WORD_ZERO);
    check("op_mode", op_mode, MODE_RESET);
    // upper control bits written as ones must be dropped
    set_mode(8'hE5);
    dev_rd(A_MODE_CTL, 16'h0011);
    dev_rd(A_SIG_LO, SIG_LO_VAL);
    dev_rd(A_SIG_HI, SIG_HI_VAL);
    dev_rd(A_CONFIRM, WORD_ZERO);
    foreach (mv[i])
    begin
      set_mode(mv[i][7:0]);
      check("op_mode", op_mode, mv[i][9:8]);
    end
    dev_rd(A_SCRATCH, WORD_ZERO);
    dev_wr(A_SCRATCH, {8'h00, sv});
    dev_rd(A_SCRATCH, {8'h00, sv});
    dev_wr(A_BYTE_ORD, 16'h0001);
    check("swap", byte_swap_en, 16'h0001);
    dev_rd(A_DATA, {flash_rdata[7:0], flash_rdata[15:8]});
    dev_wr(A_DATA, flash_rdata);
    check("flash_wdata", fw_last, {flash_rdata[7:0], flash_rdata[15:8]});
    dev_wr(A_BYTE_ORD, 16'h0100);
    check("swap", byte_swap_en, 16'h0001);
    dev_wr(A_BYTE_ORD, WORD_ZERO);
    check("swap", byte_swap_en, WORD_ZERO);
    dev_rd(A_DATA, flash_rdata);
    dev_wr(A_DATA, flash_rdata);
    check("flash_wdata", fw_last, flash_rdata);
    sw_wr(HR_ID, {8'h00, id});
    sw_rd(HR_ID, {8'h00, id}, 1'b1);
    cmd(OP_CLAIM);
    sw_rd(HR_STAT, 16'h0002, 1'b1);
    dev_rd(A_CLAIM, {8'h00, id});
    sw_rd(HR_ADDR, {3'h0, A_CLAIM}, 1'b1);
    cmd(OP_RELEASE);
    sw_rd(HR_STAT, WORD_ZERO, 1'b1);
    dev_rd(A_CLAIM, WORD_ZERO);
    set_mode(8'h15);
    dev_rd(A_MODE_CTL, 16'h0001);
    @(posedge sys_clk);
    boot_detect <= 1'b1;
    @(posedge sys_clk);
    boot_detect <= 1'b0;
    @(posedge sys_clk);
    #1 check("op_mode", op_mode, MODE_RESET);
    set_mode(8'h05);
    dev_rd(A_MODE_CTL, 16'h0009);
    dev_rd(A_SCRATCH, WORD_ZERO);
    set_mode(8'h0D);
    dev_rd(A_MODE_CTL, 16'h0001);
    @(posedge sys_clk);
    reset_input_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    reset_input_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 check("op_mode", op_mode, MODE_RESET);
    set_mode(8'h05);
    dev_rd(A_MODE_CTL, 16'h0011);
    // voltage detector pulse must also latch the hard flag
    set_mode(8'h15);
    dev_rd(A_MODE_CTL, 16'h0001);
    @(posedge sys_clk);
    volt_detect <= 1'b1;
    @(posedge sys_clk);
    volt_detect <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 check("op_mode", op_mode, MODE_RESET);
    set_mode(8'h05);
    dev_rd(A_MODE_CTL, 16'h0011);
    give_verdict();
  end
endmodule
